//--- gcil_consts.vh
// Constants for the generator set customer input logic
// How it works
// - Auto mode plus remote start requests cranking
// - Reset refused while remote start is grounded
// - Low fuel input raises low fuel warning
// - Low fuel wakes a sleeping control first
// - Each customer fault is warning or shutdown
// - Fault shows its own editable message
// - Customer faults two and three wake control
// - Fault reset clears warnings, shutdowns in auto
// - Run mode idle inhibits build-up, governs slow
// - Idle release restores normal speed and voltage
// - Idle request ignored in automatic mode
// - Idle uses lowered oil pressure trip points
// - Emergency stop shuts the set down immediately
// - Emergency stop cleared only at front panel
// - Messages sixteen characters, fault codes fixed
`ifndef GCIL_CONSTS_VH
`define GCIL_CONSTS_VH

// ****************************************
// Timing
// ****************************************
`define GCIL_CLOCK_KHZ 25000
`define GCIL_DEBOUNCE_US 10000
`define GCIL_DEBOUNCE_CYCLES (`GCIL_DEBOUNCE_US * `GCIL_CLOCK_KHZ / 1000)

// ****************************************
// Register byte offsets
// ****************************************
`define GCIL_REG_CONFIG 8'h00
`define GCIL_REG_EVENT 8'h04
`define GCIL_REG_MASK 8'h08
`define GCIL_REG_STATE 8'h0c
`define GCIL_REG_OIL_NORM 8'h10
`define GCIL_REG_OIL_IDLE 8'h14
`define GCIL_REG_CODES 8'h18
`define GCIL_REG_DISPLAY 8'h1c
`define GCIL_REG_MSG_BASE 8'h40
`define GCIL_MSG_WORDS 16

// ****************************************
// Event bit positions
// ****************************************
`define GCIL_EV_START 0
`define GCIL_EV_LOW_FUEL 1
`define GCIL_EV_CUST0 2
`define GCIL_EV_ESTOP 6
`define GCIL_EV_RESET 7
`define GCIL_EV_BITS 8

// ****************************************
// Reset values
// ****************************************
`define GCIL_CONFIG_RST 4'h0
`define GCIL_OIL_NORM_RST 32'h0014_000a
`define GCIL_OIL_IDLE_RST 32'h000a_0005
`define GCIL_MSG0_RST 128'h435553544f4d4552_204641554c543120
`define GCIL_MSG1_RST 128'h47524e4420464155_4c54202020202020
`define GCIL_MSG2_RST 128'h4441592054414e4b_2020202020202020
`define GCIL_MSG3_RST 128'h484947482047454e_2054454d50202020
`define GCIL_IDLE_RPM 12'h320
`define GCIL_NORMAL_RPM 12'h708

`endif

//--- gcil_debounce.v
// Synchroniser and debouncer for one grounded contact input
`timescale 1ns/1ps
module gcil_debounce #(
	parameter STABLE_CYCLES = 250000
)(
	input wire clock,
	input wire rstn,
	input wire raw_n,
	output reg asserted
);
	reg sync_a;
	reg sync_b;
	reg [31:0] count;

	// ****************************************
	// Two-flop synchroniser; contacts idle open (high)
	// ****************************************
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			sync_a <= 1'b1;
			sync_b <= 1'b1;
		end
		else
		begin
			sync_a <= raw_n;
			sync_b <= sync_a;
		end
	end

	// Level must hold for the full window before it is believed
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			count <= 32'h0000_0000;
			asserted <= 1'b0;
		end
		else if (~sync_b == asserted)
			count <= 32'h0000_0000;
		else if (count >= STABLE_CYCLES - 1)
		begin
			count <= 32'h0000_0000;
			asserted <= ~sync_b;
		end
		else
			count <= count + 32'h0000_0001;
	end
endmodule // gcil_debounce

//--- gcil_wake_fault.v
// Holds a fault event until the control is awake to take it
`timescale 1ns/1ps
module gcil_wake_fault #(
	parameter WAKES = 1
)(
	input wire clock,
	input wire rstn,
	input wire asserted,
	input wire awake,
	output wire wake_req,
	output wire fire
);
	reg seen;
	reg pending;
	wire may_fire;

	// Without wake ability the fault goes straight through
	assign may_fire = awake | (WAKES == 0);
	assign fire = pending & may_fire;
	assign wake_req = pending & ~may_fire;

	// ****************************************
	// Edge catch and pending hold
	// ****************************************
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			seen <= 1'b0;
			pending <= 1'b0;
		end
		else
		begin
			seen <= asserted;
			if (asserted & ~seen)
				pending <= 1'b1;
			else if (fire)
				pending <= 1'b0;
		end
	end
endmodule // gcil_wake_fault

//--- gcil_customer_inputs.v
// Customer terminal block input logic with Avalon-MM registers
`timescale 1ns/1ps
`include "gcil_consts.vh"
module gcil_customer_inputs #(
	parameter DEBOUNCE_CYCLES = `GCIL_DEBOUNCE_CYCLES,
	parameter [31:0] FAULT_CODES = 32'h04_03_02_01
)(
	input wire clock,
	input wire rstn,
	input wire remote_start_n,
	input wire low_fuel_n,
	input wire [3:0] cust_fault_n,
	input wire fault_reset_n,
	input wire engine_idle_n,
	input wire estop_n,
	input wire mode_run,
	input wire mode_auto,
	input wire control_awake,
	input wire panel_reset,
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	input wire [3:0] byteenable,
	output reg [31:0] readdata,
	output wire waitrequest,
	output wire irq,
	output reg start_req,
	output wire wake_req,
	output reg warning_active,
	output reg shutdown_active,
	output reg estop_latched,
	output reg gen_buildup_inhibit,
	output reg [11:0] speed_ref_rpm,
	output reg [15:0] oil_warn_trip,
	output reg [15:0] oil_shtd_trip,
	output reg disp_valid,
	output reg [1:0] disp_index
);
	wire rs_on;
	wire lf_on;
	wire [3:0] cf_on;
	wire fr_on;
	wire ei_on;
	wire es_on;
	wire lf_fire;
	wire lf_wake;
	wire [3:0] cf_fire;
	wire [3:0] cf_wake;
	reg [3:0] cfg_shtd;
	reg [31:0] oil_norm;
	reg [31:0] oil_idle;
	reg [127:0] msg [0:3];
	reg [`GCIL_EV_BITS-1:0] events;
	reg [`GCIL_EV_BITS-1:0] mask;
	reg lf_warn;
	reg [3:0] cf_warn;
	reg [3:0] cf_shtd;
	reg ack;
	reg [31:0] next_readdata;
	reg [`GCIL_EV_BITS-1:0] ev_hit;
	wire idle_ok;
	wire reset_ok;
	wire estop_set;
	wire cycle_end;
	wire is_msg;
	wire [3:0] msg_word;
	integer i;
	integer j;
	integer k;

	// ****************************************
	// Contact conditioning
	// ****************************************
	// One debouncer per terminal, all alike
	gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_rs (
		.clock(clock),
		.rstn(rstn),
		.raw_n(remote_start_n),
		.asserted(rs_on)
	);
	gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_lf (
		.clock(clock),
		.rstn(rstn),
		.raw_n(low_fuel_n),
		.asserted(lf_on)
	);
	gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_fr (
		.clock(clock),
		.rstn(rstn),
		.raw_n(fault_reset_n),
		.asserted(fr_on)
	);
	gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_ei (
		.clock(clock),
		.rstn(rstn),
		.raw_n(engine_idle_n),
		.asserted(ei_on)
	);
	// Stop path also debounced; a contact bounce must not trip it
	gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db_es (
		.clock(clock),
		.rstn(rstn),
		.raw_n(estop_n),
		.asserted(es_on)
	);

	// Customer faults: only inputs two and three may wake the control
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_cf
			gcil_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db (
				.clock(clock),
				.rstn(rstn),
				.raw_n(cust_fault_n[g]),
				.asserted(cf_on[g])
			);
			gcil_wake_fault #(.WAKES((g == 1) || (g == 2))) u_wf (
				.clock(clock),
				.rstn(rstn),
				.asserted(cf_on[g]),
				.awake(control_awake),
				.wake_req(cf_wake[g]),
				.fire(cf_fire[g])
			);
		end
	endgenerate

	gcil_wake_fault #(.WAKES(1)) u_wf_lf (
		.clock(clock),
		.rstn(rstn),
		.asserted(lf_on),
		.awake(control_awake),
		.wake_req(lf_wake),
		.fire(lf_fire)
	);

	assign wake_req = lf_wake | (|cf_wake);

	// ****************************************
	// Fault latches
	// ****************************************
	// Remote reset only in auto and with remote start open
	assign reset_ok = fr_on & mode_auto & ~mode_run & ~rs_on;
	assign estop_set = es_on & ~estop_latched;

	// New faults win over a reset in the same cycle
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			lf_warn <= 1'b0;
			cf_warn <= 4'h0;
			cf_shtd <= 4'h0;
		end
		else
		begin
			lf_warn <= lf_fire | (lf_warn & ~reset_ok);
			for (j = 0; j < 4; j = j + 1)
			begin
				cf_warn[j] <= (cf_fire[j] & ~cfg_shtd[j]) | (cf_warn[j] & ~reset_ok);
				cf_shtd[j] <= (cf_fire[j] & cfg_shtd[j]) | (cf_shtd[j] & ~reset_ok);
			end
		end
	end

	// Stop latch ignores the remote reset entirely
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			estop_latched <= 1'b0;
		else if (es_on)
			estop_latched <= 1'b1;
		else if (panel_reset)
			estop_latched <= 1'b0;
	end

	// ****************************************
	// Run, idle and oil outputs
	// ****************************************
	// Idle only in manual run; auto quietly drops it
	assign idle_ok = ei_on & mode_run & ~mode_auto;

	// Registered so the engine side sees clean levels
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			start_req <= 1'b0;
			warning_active <= 1'b0;
			shutdown_active <= 1'b0;
			gen_buildup_inhibit <= 1'b0;
			speed_ref_rpm <= `GCIL_NORMAL_RPM;
			oil_warn_trip <= 16'h000a;
			oil_shtd_trip <= 16'h0014;
		end
		else
		begin
			// Stop dominates: a latched shutdown blocks cranking
			start_req <= mode_auto & ~mode_run & rs_on & ~shutdown_active & ~es_on;
			warning_active <= lf_warn | (|cf_warn);
			shutdown_active <= estop_latched | es_on | (|cf_shtd);
			gen_buildup_inhibit <= idle_ok;
			speed_ref_rpm <= idle_ok ? `GCIL_IDLE_RPM : `GCIL_NORMAL_RPM;
			oil_warn_trip <= idle_ok ? oil_idle[15:0] : oil_norm[15:0];
			oil_shtd_trip <= idle_ok ? oil_idle[31:16] : oil_norm[31:16];
		end
	end

	// Display follows the latest customer fault raised
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			disp_index <= 2'h0;
			disp_valid <= 1'b0;
		end
		else
		begin
			disp_valid <= |(cf_warn | cf_shtd);
			for (k = 0; k < 4; k = k + 1)
				if (cf_fire[k])
					disp_index <= k[1:0];
		end
	end

	// ****************************************
	// Bus slave
	// ****************************************
	// One wait cycle, then the answer; readdata registered
	assign waitrequest = (read | write) & ~ack;
	assign cycle_end = (read | write) & ack;
	assign is_msg = address[7:6] == 2'h1;
	assign msg_word = address[5:2];

	// Read mux; unmapped words read zero
	always @*
	begin
		next_readdata = 32'h0000_0000;
		if (is_msg)
			next_readdata = msg[msg_word[3:2]][127 - 32 * msg_word[1:0] -: 32];
		else
			case (address)
				`GCIL_REG_CONFIG: next_readdata = {28'h0, cfg_shtd};
				`GCIL_REG_EVENT: next_readdata = {24'h0, events};
				`GCIL_REG_MASK: next_readdata = {24'h0, mask};
				`GCIL_REG_STATE: next_readdata = {19'h0, wake_req, start_req, gen_buildup_inhibit,
					estop_latched, cf_shtd, cf_warn, lf_warn};
				`GCIL_REG_OIL_NORM: next_readdata = oil_norm;
				`GCIL_REG_OIL_IDLE: next_readdata = oil_idle;
				`GCIL_REG_CODES: next_readdata = FAULT_CODES;
				`GCIL_REG_DISPLAY: next_readdata = {29'h0, disp_valid, disp_index};
				default: next_readdata = 32'h0000_0000;
			endcase
	end

	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			ack <= 1'b0;
			readdata <= 32'h0000_0000;
		end
		else
		begin
			ack <= waitrequest;
			if (read & ~ack)
				readdata <= next_readdata;
		end
	end

	// Writable registers, byte lanes honoured
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
		begin
			cfg_shtd <= `GCIL_CONFIG_RST;
			mask <= 8'h00;
			oil_norm <= `GCIL_OIL_NORM_RST;
			oil_idle <= `GCIL_OIL_IDLE_RST;
			msg[0] <= `GCIL_MSG0_RST;
			msg[1] <= `GCIL_MSG1_RST;
			msg[2] <= `GCIL_MSG2_RST;
			msg[3] <= `GCIL_MSG3_RST;
		end
		else if (write & cycle_end)
		begin
			if (is_msg)
			begin
				// Fixed sixteen-character store; codes live elsewhere
				for (i = 0; i < 4; i = i + 1)
					if (byteenable[i])
						msg[msg_word[3:2]][127 - 32 * msg_word[1:0] - 24 + 8 * i -: 8] <=
							writedata[8 * i +: 8];
			end
			else
				case (address)
					`GCIL_REG_CONFIG:
						if (byteenable[0])
							cfg_shtd <= writedata[3:0];
					`GCIL_REG_MASK:
						if (byteenable[0])
							mask <= writedata[7:0];
					`GCIL_REG_OIL_NORM:
						for (i = 0; i < 4; i = i + 1)
							if (byteenable[i])
								oil_norm[8 * i +: 8] <= writedata[8 * i +: 8];
					`GCIL_REG_OIL_IDLE:
						for (i = 0; i < 4; i = i + 1)
							if (byteenable[i])
								oil_idle[8 * i +: 8] <= writedata[8 * i +: 8];
					default: ;
				endcase
		end
	end

	// ****************************************
	// Events and interrupt
	// ****************************************
	always @*
	begin
		ev_hit = {`GCIL_EV_BITS{1'b0}};
		ev_hit[`GCIL_EV_START] = mode_auto & ~mode_run & rs_on & ~start_req & ~shutdown_active & ~es_on;
		ev_hit[`GCIL_EV_LOW_FUEL] = lf_fire;
		ev_hit[`GCIL_EV_CUST0 +: 4] = cf_fire;
		ev_hit[`GCIL_EV_ESTOP] = estop_set;
		ev_hit[`GCIL_EV_RESET] = reset_ok & (lf_warn | (|cf_warn) | (|cf_shtd));
	end

	// Read clears, but an event in the same cycle survives
	always @(posedge clock or negedge rstn)
	begin
		if (!rstn)
			events <= {`GCIL_EV_BITS{1'b0}};
		else if (read & cycle_end & (address == `GCIL_REG_EVENT))
			events <= ev_hit;
		else
			events <= events | ev_hit;
	end

	assign irq = |(events & mask);
endmodule // gcil_customer_inputs

//--- gcil_assertions.sv
// Port checks for the customer input block
`timescale 1ns/1ps
module gcil_assertions (
	input wire clock,
	input wire rstn,
	input wire mode_auto,
	input wire control_awake,
	input wire panel_reset,
	input wire read,
	input wire write,
	input wire [31:0] readdata,
	input wire waitrequest,
	input wire start_req,
	input wire wake_req,
	input wire warning_active,
	input wire shutdown_active,
	input wire estop_latched,
	input wire gen_buildup_inhibit,
	input wire [11:0] speed_ref_rpm
);
	// ****
	// Checks
	// ****
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn);
	// One wait state, then a fresh one
	AST_WAIT: assert property ($rose(read) || $rose(write) |-> waitrequest ##1 !waitrequest) else $error("bad wait");
	AST_REARM: assert property ((read || write) && !waitrequest |=> waitrequest || !(read || write)) else $error("no rearm");
	AST_READ: assert property (!read |=> $stable(readdata)) else $error("readdata moved");
	AST_SPEED: assert property (speed_ref_rpm == (gen_buildup_inhibit ? 12'h320 : 12'h708)) else $error("speed");
	AST_IDLE_AUTO: assert property (mode_auto [*4] |-> !gen_buildup_inhibit) else $error("idle in auto");
	AST_START: assert property ($rose(start_req) |-> $past(mode_auto)) else $error("start outside auto");
	AST_WAKE: assert property (wake_req ##1 control_awake |-> ##[1:3] (warning_active || shutdown_active))
		else $error("wake fault lost");
	AST_ESTOP_SHTD: assert property (estop_latched |-> shutdown_active) else $error("stop not shut");
	AST_ESTOP_HOLD: assert property ($fell(estop_latched) |-> $past(panel_reset) || $past(panel_reset, 2))
		else $error("stop cleared");
	// Main scenarios reached
	cover property ($rose(start_req));
	cover property ($rose(estop_latched));
	cover property ($rose(gen_buildup_inhibit));
endmodule // gcil_assertions

bind gcil_customer_inputs gcil_assertions gcil_assertions_inst (.clock(clock), .rstn(rstn), .mode_auto(mode_auto),
	.control_awake(control_awake), .panel_reset(panel_reset), .read(read), .write(write), .readdata(readdata),
	.waitrequest(waitrequest), .start_req(start_req), .wake_req(wake_req), .warning_active(warning_active),
	.shutdown_active(shutdown_active),
	.estop_latched(estop_latched), .gen_buildup_inhibit(gen_buildup_inhibit), .speed_ref_rpm(speed_ref_rpm));

//--- gcil_contacts.sv
// Remote switches and sensing contacts on the terminal block
`timescale 1ns/1ps
module gcil_contacts (
	input wire clock,
	input wire [8:0] closed,
	output reg [8:0] pin_n
);
	reg [8:0] last;
	reg [8:0] moving;
	reg [1:0] bounce;
	// ****
	// Contacts
	// ****
	// Open contacts sit high on their pull-ups
	initial
	begin
		pin_n = 9'h1ff;
		last = 9'h000;
		moving = 9'h000;
		bounce = 2'h0;
	end
	// A contact that moves chatters three cycles, as real ones do
	always @(posedge clock)
	begin
		if (closed != last)
		begin
			bounce <= 2'h3;
			moving <= closed ^ last;
		end
		else if (bounce != 2'h0)
			bounce <= bounce - 2'h1;
		last <= closed;
		pin_n <= ~closed ^ (bounce[0] ? moving : 9'h000);
	end
endmodule // gcil_contacts

//--- gcil_customer_inputs_bench.sv
// Self-checking bench for the customer input block
`timescale 1ns/1ps
`include "gcil_consts.vh"
module gcil_customer_inputs_bench;
	reg clock, rstn, mode_run, mode_auto, control_awake, panel_reset, read, write;
	reg [8:0] closed;
	reg [7:0] address;
	reg [31:0] writedata, q;
	wire [8:0] pin_n;
	wire [31:0] readdata;
	wire [11:0] speed_ref_rpm;
	wire [15:0] oil_warn_trip, oil_shtd_trip;
	wire [1:0] disp_index;
	wire waitrequest, irq, start_req, wake_req, warning_active, shutdown_active;
	wire estop_latched, gen_buildup_inhibit, disp_valid;
	integer fail_count, compares;
	// Short debounce keeps the run brief
	gcil_customer_inputs #(.DEBOUNCE_CYCLES(4)) gcil_customer_inputs_inst (.clock(clock), .rstn(rstn),
		.remote_start_n(pin_n[0]), .low_fuel_n(pin_n[1]), .cust_fault_n(pin_n[5:2]), .fault_reset_n(pin_n[6]),
		.engine_idle_n(pin_n[7]), .estop_n(pin_n[8]), .mode_run(mode_run), .mode_auto(mode_auto),
		.control_awake(control_awake), .panel_reset(panel_reset), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
		.start_req(start_req), .wake_req(wake_req), .warning_active(warning_active),
		.shutdown_active(shutdown_active), .estop_latched(estop_latched), .gen_buildup_inhibit(gen_buildup_inhibit),
		.speed_ref_rpm(speed_ref_rpm), .oil_warn_trip(oil_warn_trip), .oil_shtd_trip(oil_shtd_trip),
		.disp_valid(disp_valid), .disp_index(disp_index));
	gcil_contacts gcil_contacts_inst (.clock(clock), .closed(closed), .pin_n(pin_n));
	// ****
	// Support
	// ****
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Run needs about 460 cycles; allow far more
	initial
	begin
		#400000;
		fail_count = fail_count + 1;
		give_verdict;
	end
	task chk(input [31:0] seen, input [31:0] want);
	begin
		compares = compares + 1;
		if (seen !== want)
		begin
			fail_count = fail_count + 1;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, want);
		end
	end
	endtask
	task give_verdict;
	begin
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	// Avalon access; held until waitrequest is seen low at a rising edge
	task bus(input wr, input [7:0] a, input [31:0] d);
	begin
		address <= a;
		writedata <= d;
		read <= !wr;
		write <= wr;
		@(posedge clock);
		while (waitrequest !== 1'b0)
			@(posedge clock);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clock);
	end
	endtask
	// Chatter, debounce and latch all fit in this span
	task settle;
		repeat (24) @(posedge clock);
	endtask
	// ****
	// Scenarios
	// ****
	task t_regs;
	begin
		bus(0, 8'h20, 32'h0);
		chk(q, 32'h0);
		bus(1, `GCIL_REG_CODES, 32'hffff_ffff);
		bus(0, `GCIL_REG_CODES, 32'h0);
		chk(q, 32'h0403_0201);
		bus(0, `GCIL_REG_MSG_BASE + 8'h10, 32'h0);
		chk(q, 32'h4752_4e44);
		bus(1, `GCIL_REG_MSG_BASE + 8'h10, 32'h5055_4d50);
		bus(0, `GCIL_REG_MSG_BASE + 8'h10, 32'h0);
		chk(q, 32'h5055_4d50);
	end
	endtask
	task t_start;
	begin
		bus(1, `GCIL_REG_MASK, 32'h1);
		closed <= 9'h001;
		settle;
		chk({start_req, irq}, 2'h3);
		bus(0, `GCIL_REG_EVENT, 32'h0);
		chk({q[0], irq}, 2'h2);
		closed <= 9'h000;
		settle;
	end
	endtask
	task t_faults;
	begin
		bus(1, `GCIL_REG_CONFIG, 32'h2);
		control_awake <= 1'b0;
		closed <= 9'h008;
		settle;
		chk({wake_req, shutdown_active}, 2'h2);
		control_awake <= 1'b1;
		settle;
		chk({wake_req, shutdown_active, warning_active, disp_valid, disp_index}, 6'h15);
		control_awake <= 1'b0;
		closed <= 9'h00a;
		settle;
		chk({wake_req, warning_active}, 2'h2);
		control_awake <= 1'b1;
		closed <= 9'h00e;
		settle;
		chk({warning_active, disp_index}, 3'h4);
		bus(0, `GCIL_REG_STATE, 32'h0);
		chk(q[12:0], 13'h0043);
		closed <= 9'h000;
		settle;
	end
	endtask
	task t_reset;
	begin
		closed <= 9'h041;
		settle;
		chk({warning_active, shutdown_active}, 2'h3);
		mode_auto <= 1'b0;
		mode_run <= 1'b1;
		closed <= 9'h040;
		settle;
		chk({warning_active, shutdown_active}, 2'h3);
		mode_auto <= 1'b1;
		mode_run <= 1'b0;
		closed <= 9'h000;
		settle;
		closed <= 9'h040;
		settle;
		chk({warning_active, shutdown_active, disp_valid}, 3'h0);
	end
	endtask
	task t_estop;
	begin
		closed <= 9'h140;
		settle;
		chk({estop_latched, shutdown_active}, 2'h3);
		bus(0, `GCIL_REG_EVENT, 32'h0);
		chk(q, 32'h0000_00ce);
		panel_reset <= 1'b1;
		@(posedge clock);
		panel_reset <= 1'b0;
		closed <= 9'h000;
		settle;
		chk(estop_latched, 1'b1);
		panel_reset <= 1'b1;
		@(posedge clock);
		panel_reset <= 1'b0;
		settle;
		chk(estop_latched, 1'b0);
	end
	endtask
	task t_idle;
	begin
		closed <= 9'h080;
		settle;
		chk(gen_buildup_inhibit, 1'b0);
		mode_auto <= 1'b0;
		mode_run <= 1'b1;
		settle;
		chk({gen_buildup_inhibit, speed_ref_rpm}, 13'h1320);
		chk({oil_shtd_trip, oil_warn_trip}, `GCIL_OIL_IDLE_RST);
		closed <= 9'h000;
		settle;
		chk({gen_buildup_inhibit, speed_ref_rpm}, 13'h0708);
		chk({oil_shtd_trip, oil_warn_trip}, `GCIL_OIL_NORM_RST);
	end
	endtask
	// Reset for ten cycles, then every scenario in turn
	initial
	begin
		rstn = 1'b0;
		closed = 9'h000;
		mode_run = 1'b0;
		mode_auto = 1'b1;
		control_awake = 1'b1;
		panel_reset = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		fail_count = 0;
		compares = 0;
		repeat (10) @(posedge clock);
		rstn <= 1'b1;
		@(posedge clock);
		t_regs;
		t_start;
		t_faults;
		t_reset;
		t_estop;
		t_idle;
		give_verdict;
	end
endmodule // gcil_customer_inputs_bench
